// File: shared/vcif_pkg.sv
// constants, types and field layout of the virtual cpu interface control block
// assumes a single system clock and the processor's register access port
// Operation
// [RL1] priority mask in control bits 31:24
// [RL2] group 0 binary point in bits 23:21
// [RL3] group 1 binary point in bits 20:18
// [RL4] bit 9 splits end-of-interrupt from deactivation
// [RL5] common point: group 1 reads point0+1, saturated
// [RL6] bit 3 routes group 0 as fast interrupt
// [RL7] bit 2 clear: group 1 acknowledge returns 1022
// [RL8] bit 1 enables group 1
// [RL9] bit 0 enables group 0
// [RL10] hypervisor and guest share the same storage
// [RL11] no hypervisor: control reads zero from monitor
// [RL12] type bits 31:29 priority bits minus one
// [RL13] type bits 28:26 preemption bits minus one
// [RL14] type bits 25:23 identifier width code
// [RL15] type bit 22 error interrupt support
// [RL16] type bit 21 top affinity support
// [RL17] type bit 20 no direct injection
// [RL18] no hypervisor: type zero except bit 20
// [RL19] type bit 19 deactivate trap support
// [RL20] hypervisor access undefined without sysreg enable
// [RL21] trapped kernel accesses go to hypervisor
// [RL22] type bits 4:0 list count, 18:5 zero
// [RL23] reserved control bits read zero, ignore writes
package vcif_pkg;
  // control register field positions
  localparam int CTL_PMR_LSB = 24;
  localparam int CTL_BPR0_LSB = 21;
  localparam int CTL_BPR1_LSB = 18;
  localparam int CTL_EOIM_BIT = 9;
  localparam int CTL_CBPR_BIT = 4;
  localparam int CTL_FIQ_BIT = 3;
  localparam int CTL_ACK_BIT = 2;
  localparam int CTL_EN1_BIT = 1;
  localparam int CTL_EN0_BIT = 0;
  // type register field positions
  localparam int TYP_PRI_LSB = 29;
  localparam int TYP_PRE_LSB = 26;
  localparam int TYP_ID_LSB = 23;
  localparam int TYP_ERROR_INTERRUPT_SUPPORT_BIT = 22;
  localparam int TYP_A3V_BIT = 21;
  localparam int TYP_NV4_BIT = 20;
  localparam int TYP_TDS_BIT = 19;
  localparam int TYP_LR_LSB = 0;
  // implementation choices reported by the type register
  localparam logic [2:0] TYP_PRI_VAL = 3'h4;
  localparam logic [2:0] TYP_PRE_VAL = 3'h4;
  localparam logic [2:0] TYP_ID_VAL = 3'h0;
  localparam logic TYP_ERROR_INTERRUPT_SUPPORT_VAL = 1'b0;
  localparam logic TYP_A3V_VAL = 1'b0;
  localparam logic TYP_NV4_VAL = 1'b1;
  localparam logic TYP_TDS_VAL = 1'b0;
  localparam logic [4:0] TYP_LR_VAL = 5'h03;
  // set when the sysreg enable of the guest is hard-wired to one
  localparam logic SRE_FIXED_ONE = 1'b0;
  // guest control word layout
  localparam int GCTL_CBPR_BIT = 0;
  localparam int GCTL_EOIM_BIT = 1;
  localparam int GCTL_FIQ_BIT = 2;
  localparam int GCTL_ACK_BIT = 3;
  // reset values and the binary point maximum
  localparam logic [7:0] RST_PMR = 8'h00;
  localparam logic [2:0] RST_BPR0 = 3'h0;
  localparam logic [2:0] RST_BPR1 = 3'h1;
  localparam logic [2:0] BPR_MAX = 3'h7;
  // special identifiers
  localparam int ID_W = 24;
  localparam logic [23:0] ID_GRP1_ALT = 24'h0003fe;
  localparam logic [23:0] ID_SPURIOUS = 24'h0003ff;

  typedef enum logic [1:0] {
    VCIF_LVL_USER = 2'h0,
    VCIF_LVL_KERNEL = 2'h1,
    VCIF_LVL_HYP = 2'h2,
    VCIF_LVL_MON = 2'h3
  } vcif_lvl_t;

  typedef enum logic {
    VCIF_SEL_CTL = 1'b0,
    VCIF_SEL_TYPE = 1'b1
  } vcif_sel_t;

  typedef enum logic [2:0] {
    VCIF_G_PMR = 3'h0,
    VCIF_G_BPR0 = 3'h1,
    VCIF_G_BPR1 = 3'h2,
    VCIF_G_CTL = 3'h3,
    VCIF_G_EN0 = 3'h4,
    VCIF_G_EN1 = 3'h5
  } vcif_gsel_t;
endpackage

// File: rtl/vcif_grp_prio.sv
// group priority extraction from a priority and a binary point
// purely combinational, used by the control block on the same clock
`timescale 1ns/100ps
module vcif_grp_prio (
  input wire logic [2:0] i_bpr,
  input wire logic i_grp1_point,
  input wire logic [7:0] i_prio,
  output logic [7:0] o_gprio
);
  logic [3:0] shift;
  logic [7:0] mask;

  // a group 1 point keeps one more group bit than a group 0 point
  always_comb begin
    shift = i_grp1_point ? {1'b0, i_bpr} : ({1'b0, i_bpr} + 4'h1);
    mask = 8'hff << shift;
    o_gprio = i_prio & mask;
  end
endmodule

// File: rtl/vcif_ctrl_regs.sv
// virtual cpu interface control and type registers with guest aliases
// assumes request pulses from logic on the same clock; no synchronisers needed
`timescale 1ns/100ps
module vcif_ctrl_regs (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // hypervisor-side system register port
  input wire logic i_hyp_present,
  input wire logic i_hyp_sre,
  input wire logic i_mon_sre,
  input wire logic i_cp15_trap,
  input wire logic i_acc_req,
  input wire logic i_acc_write,
  input wire logic i_acc_ns,
  input wire vcif_pkg::vcif_lvl_t i_acc_lvl,
  input wire vcif_pkg::vcif_sel_t i_acc_sel,
  input wire logic [31:0] i_acc_wdata,
  output logic o_acc_done,
  output logic o_acc_undef,
  output logic o_acc_trap,
  output logic [31:0] o_acc_rdata,
  // guest-side alias port
  input wire logic i_gst_req,
  input wire logic i_gst_write,
  input wire vcif_pkg::vcif_gsel_t i_gst_sel,
  input wire logic [7:0] i_gst_wdata,
  output logic o_gst_done,
  output logic [7:0] o_gst_rdata,
  // highest pending virtual interrupt and running priority
  input wire logic i_pend_valid,
  input wire logic i_pend_grp1,
  input wire logic [7:0] i_pend_prio,
  input wire logic [23:0] i_pend_id,
  input wire logic i_run_active,
  input wire logic [7:0] i_run_prio,
  output logic o_virq,
  output logic o_vfiq,
  // acknowledge, end-of-interrupt and deactivate requests
  input wire logic i_ack_req,
  input wire logic i_eoi_req,
  input wire logic i_dir_req,
  output logic o_ack_valid,
  output logic [23:0] o_ack_id,
  output logic o_prio_drop,
  output logic o_deact,
  output logic o_dir_unpred
);
  import vcif_pkg::*;

  // single storage for both views
  logic [7:0] pmr_r;
  logic [2:0] bpr0_r;
  logic [2:0] bpr1_r;
  logic eoim_r;
  logic cbpr_r;
  logic fiq_r;
  logic ack_r;
  logic en1_r;
  logic en0_r;

  logic acc_undef;
  logic acc_trap;
  logic acc_ok;
  logic hyp_wr;
  logic gst_wr;
  logic fiq_eff;
  logic ack_eff;
  logic [2:0] bpr1_view;
  logic [31:0] ctl_word;
  logic [31:0] typ_word;
  logic [31:0] acc_rdata_nxt;
  logic [7:0] gst_rdata_nxt;
  logic [7:0] pend_gprio;
  logic [7:0] run_gprio;
  logic [2:0] pre_bpr;
  logic pre_grp1_point;
  logic pend_enabled;
  logic pend_signal;

  // access classification
  always_comb begin
    acc_trap = 1'b0;
    acc_undef = 1'b0;
    unique case (i_acc_lvl)
      VCIF_LVL_USER: acc_undef = 1'b1;
      VCIF_LVL_KERNEL: begin
        // only reachable as a trap; otherwise no access at this level
        acc_trap = i_hyp_present && i_acc_ns && i_cp15_trap; // [RL21]
        acc_undef = !acc_trap;
      end
      VCIF_LVL_HYP: begin
        acc_undef = !i_hyp_present || !i_hyp_sre; // [RL20]
      end
      VCIF_LVL_MON: begin
        acc_undef = i_acc_ns && !i_mon_sre;
      end
    endcase
    // the type register cannot be written
    if (i_acc_write && (i_acc_sel == VCIF_SEL_TYPE) && !acc_trap) begin
      acc_undef = 1'b1;
    end
    acc_ok = !acc_undef && !acc_trap;
  end

  // monitor writes are dropped while there is no hypervisor level
  assign hyp_wr = i_acc_req && acc_ok && i_acc_write && (i_acc_sel == VCIF_SEL_CTL) &&
                  i_hyp_present;
  // hypervisor write wins a same-cycle collision with the guest
  assign gst_wr = i_gst_req && i_gst_write && !hyp_wr;

  // hard-wired views when the guest sysreg enable is fixed
  assign fiq_eff = SRE_FIXED_ONE ? 1'b1 : fiq_r; // [RL6]
  assign ack_eff = SRE_FIXED_ONE ? 1'b0 : ack_r; // [RL7]

  // common point view of the group 1 binary point
  always_comb begin
    if (cbpr_r) begin
      bpr1_view = (bpr0_r == BPR_MAX) ? BPR_MAX : (bpr0_r + 3'h1); // [RL5]
    end else begin
      bpr1_view = bpr1_r;
    end
  end

  // register words; reserved bits stay zero
  always_comb begin
    ctl_word = 32'h0000_0000; // [RL23]
    ctl_word[CTL_PMR_LSB +: 8] = pmr_r; // [RL1]
    ctl_word[CTL_BPR0_LSB +: 3] = bpr0_r; // [RL2]
    ctl_word[CTL_BPR1_LSB +: 3] = bpr1_r; // [RL3]
    ctl_word[CTL_EOIM_BIT] = eoim_r; // [RL4]
    ctl_word[CTL_CBPR_BIT] = cbpr_r; // [RL5]
    ctl_word[CTL_FIQ_BIT] = fiq_eff; // [RL6]
    ctl_word[CTL_ACK_BIT] = ack_eff; // [RL7]
    ctl_word[CTL_EN1_BIT] = en1_r; // [RL8]
    ctl_word[CTL_EN0_BIT] = en0_r; // [RL9]
  end

  always_comb begin
    typ_word = 32'h0000_0000; // [RL22]
    typ_word[TYP_PRI_LSB +: 3] = TYP_PRI_VAL; // [RL12]
    typ_word[TYP_PRE_LSB +: 3] = TYP_PRE_VAL; // [RL13]
    typ_word[TYP_ID_LSB +: 3] = TYP_ID_VAL; // [RL14]
    typ_word[TYP_ERROR_INTERRUPT_SUPPORT_BIT] = TYP_ERROR_INTERRUPT_SUPPORT_VAL; // [RL15]
    typ_word[TYP_A3V_BIT] = TYP_A3V_VAL; // [RL16]
    typ_word[TYP_NV4_BIT] = TYP_NV4_VAL; // [RL17]
    typ_word[TYP_TDS_BIT] = TYP_TDS_VAL; // [RL19]
    typ_word[TYP_LR_LSB +: 5] = TYP_LR_VAL; // [RL22]
  end

  // hypervisor read data
  always_comb begin
    acc_rdata_nxt = 32'h0000_0000;
    if (acc_ok && !i_acc_write) begin
      if (!i_hyp_present) begin
        if (i_acc_sel == VCIF_SEL_TYPE) begin
          acc_rdata_nxt[TYP_NV4_BIT] = 1'b1; // [RL18]
        end
        // control reads as zero here // [RL11]
      end else if (i_acc_sel == VCIF_SEL_TYPE) begin
        acc_rdata_nxt = typ_word;
      end else begin
        acc_rdata_nxt = ctl_word;
      end
    end
  end

  // guest read data through the same storage
  always_comb begin
    gst_rdata_nxt = 8'h00;
    unique case (i_gst_sel)
      VCIF_G_PMR: gst_rdata_nxt = pmr_r;
      VCIF_G_BPR0: gst_rdata_nxt = {5'h00, bpr0_r};
      VCIF_G_BPR1: gst_rdata_nxt = {5'h00, bpr1_view}; // [RL5]
      VCIF_G_CTL: begin
        gst_rdata_nxt[GCTL_CBPR_BIT] = cbpr_r;
        gst_rdata_nxt[GCTL_EOIM_BIT] = eoim_r;
        gst_rdata_nxt[GCTL_FIQ_BIT] = fiq_eff;
        gst_rdata_nxt[GCTL_ACK_BIT] = ack_eff;
      end
      VCIF_G_EN0: gst_rdata_nxt = {7'h00, en0_r};
      VCIF_G_EN1: gst_rdata_nxt = {7'h00, en1_r};
      default: gst_rdata_nxt = 8'h00;
    endcase
  end

  // priority mask and binary points
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pmr_r <= RST_PMR;
      bpr0_r <= RST_BPR0;
      bpr1_r <= RST_BPR1;
    end else if (hyp_wr) begin
      pmr_r <= i_acc_wdata[CTL_PMR_LSB +: 8]; // [RL1] [RL10]
      bpr0_r <= i_acc_wdata[CTL_BPR0_LSB +: 3]; // [RL2]
      bpr1_r <= i_acc_wdata[CTL_BPR1_LSB +: 3]; // [RL3]
    end else if (gst_wr) begin
      unique case (i_gst_sel)
        VCIF_G_PMR: pmr_r <= i_gst_wdata; // [RL10]
        VCIF_G_BPR0: bpr0_r <= i_gst_wdata[2:0];
        VCIF_G_BPR1: begin
          // ignored while the common point is in force
          if (!cbpr_r) begin
            bpr1_r <= i_gst_wdata[2:0]; // [RL5]
          end
        end
        default: begin
        end
      endcase
    end
  end

  // control bits and group enables
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      eoim_r <= 1'b0;
      cbpr_r <= 1'b0;
      fiq_r <= 1'b0;
      ack_r <= 1'b0;
      en1_r <= 1'b0;
      en0_r <= 1'b0;
    end else if (hyp_wr) begin
      eoim_r <= i_acc_wdata[CTL_EOIM_BIT]; // [RL4]
      cbpr_r <= i_acc_wdata[CTL_CBPR_BIT]; // [RL5]
      fiq_r <= i_acc_wdata[CTL_FIQ_BIT]; // [RL6]
      ack_r <= i_acc_wdata[CTL_ACK_BIT]; // [RL7]
      en1_r <= i_acc_wdata[CTL_EN1_BIT]; // [RL8]
      en0_r <= i_acc_wdata[CTL_EN0_BIT]; // [RL9]
    end else if (gst_wr) begin
      unique case (i_gst_sel)
        VCIF_G_CTL: begin
          cbpr_r <= i_gst_wdata[GCTL_CBPR_BIT]; // [RL10]
          eoim_r <= i_gst_wdata[GCTL_EOIM_BIT];
          fiq_r <= i_gst_wdata[GCTL_FIQ_BIT];
          ack_r <= i_gst_wdata[GCTL_ACK_BIT];
        end
        VCIF_G_EN0: en0_r <= i_gst_wdata[0];
        VCIF_G_EN1: en1_r <= i_gst_wdata[0];
        default: begin
        end
      endcase
    end
  end

  // hypervisor access answer, one cycle after the request
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_acc_done <= 1'b0;
      o_acc_undef <= 1'b0;
      o_acc_trap <= 1'b0;
      o_acc_rdata <= 32'h0000_0000;
    end else begin
      o_acc_done <= i_acc_req;
      o_acc_undef <= i_acc_req && acc_undef; // [RL20]
      o_acc_trap <= i_acc_req && acc_trap; // [RL21]
      o_acc_rdata <= i_acc_req ? acc_rdata_nxt : 32'h0000_0000;
    end
  end

  // guest access answer
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_gst_done <= 1'b0;
      o_gst_rdata <= 8'h00;
    end else begin
      o_gst_done <= i_gst_req;
      o_gst_rdata <= (i_gst_req && !i_gst_write) ? gst_rdata_nxt : 8'h00;
    end
  end

  // preemption uses point 0 for group 0, and for group 1 under the common point
  always_comb begin
    if (!i_pend_grp1 || cbpr_r) begin
      pre_bpr = bpr0_r; // [RL2]
      pre_grp1_point = 1'b0;
    end else begin
      pre_bpr = bpr1_r; // [RL3]
      pre_grp1_point = 1'b1;
    end
  end

  vcif_grp_prio u_pend_gp (
    .i_bpr(pre_bpr),
    .i_grp1_point(pre_grp1_point),
    .i_prio(i_pend_prio),
    .o_gprio(pend_gprio)
  );

  vcif_grp_prio u_run_gp (
    .i_bpr(pre_bpr),
    .i_grp1_point(pre_grp1_point),
    .i_prio(i_run_prio),
    .o_gprio(run_gprio)
  );

  // lower value is higher priority
  assign pend_enabled = i_pend_grp1 ? en1_r : en0_r; // [RL8] [RL9]
  assign pend_signal = i_pend_valid && pend_enabled && (i_pend_prio < pmr_r) && // [RL1]
                       (!i_run_active || (pend_gprio < run_gprio));

  // interrupt lines toward the processor
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_virq <= 1'b0;
      o_vfiq <= 1'b0;
    end else begin
      o_virq <= pend_signal && (i_pend_grp1 || !fiq_eff); // [RL6]
      o_vfiq <= pend_signal && !i_pend_grp1 && fiq_eff; // [RL6]
    end
  end

  // acknowledge answer path, registered one cycle after the request
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ack_valid <= 1'b0;
      o_ack_id <= ID_SPURIOUS;
    end else begin
      o_ack_valid <= i_ack_req;
      if (i_ack_req) begin
        if (!i_pend_valid) begin
          o_ack_id <= ID_SPURIOUS;
        end else if (i_pend_grp1 && !ack_eff) begin
          o_ack_id <= ID_GRP1_ALT; // [RL7]
        end else begin
          o_ack_id <= i_pend_id; // [RL7]
        end
      end
    end
  end

  // end of interrupt and deactivation
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prio_drop <= 1'b0;
      o_deact <= 1'b0;
      o_dir_unpred <= 1'b0;
    end else begin
      o_prio_drop <= i_eoi_req; // [RL4]
      o_deact <= (i_eoi_req && !eoim_r) || (i_dir_req && eoim_r); // [RL4]
      // flagged instead of acted on while deactivation rides on eoi
      o_dir_unpred <= i_dir_req && !eoim_r; // [RL4]
    end
  end
endmodule

// File: tb/vcif_ctrl_assertions.sv
// assertions on the access, ack and signalling ports of the control block
// bound into vcif_ctrl_regs; one clock, asynchronous active-low reset
`timescale 1ns/100ps
module vcif_ctrl_assertions
  import vcif_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_hyp_present,
  input wire logic i_hyp_sre,
  input wire logic i_cp15_trap,
  input wire logic i_acc_req,
  input wire logic i_acc_write,
  input wire logic i_acc_ns,
  input wire vcif_pkg::vcif_lvl_t i_acc_lvl,
  input wire vcif_pkg::vcif_sel_t i_acc_sel,
  input wire logic o_acc_done,
  input wire logic o_acc_undef,
  input wire logic o_acc_trap,
  input wire logic [31:0] o_acc_rdata,
  input wire logic i_pend_valid,
  input wire logic o_virq,
  input wire logic o_vfiq,
  input wire logic i_ack_req,
  input wire logic i_eoi_req,
  input wire logic i_dir_req,
  input wire logic o_ack_valid,
  input wire logic [23:0] o_ack_id,
  input wire logic o_prio_drop,
  input wire logic o_deact,
  input wire logic o_dir_unpred
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // secure monitor read with no hypervisor level
  sequence s_mon_rd;
    i_acc_req && !i_acc_write && !i_acc_ns && i_acc_lvl == VCIF_LVL_MON && !i_hyp_present;
  endsequence
  sequence s_clean;
    o_acc_done && !o_acc_undef && !o_acc_trap;
  endsequence
  acc_answer_a: assert property (
    i_acc_req |=> o_acc_done) else $error("access not answered");
  hyp_undef_a: assert property (
    i_acc_req && i_acc_lvl == VCIF_LVL_HYP && !i_hyp_sre |=> o_acc_undef)
    else $error("hyp access not undefined");
  kernel_trap_a: assert property (
    i_acc_req && i_acc_lvl == VCIF_LVL_KERNEL && i_hyp_present && i_acc_ns && i_cp15_trap
    |=> o_acc_trap && !o_acc_undef) else $error("kernel access not trapped");
  mon_ctl_a: assert property (
    s_mon_rd ##0 i_acc_sel == VCIF_SEL_CTL |=> s_clean ##0 o_acc_rdata == 32'h00000000)
    else $error("control not zero from monitor");
  mon_type_a: assert property (
    s_mon_rd ##0 i_acc_sel == VCIF_SEL_TYPE |=> s_clean ##0 o_acc_rdata == 32'h00100000)
    else $error("type not fixed from monitor");
  type_word_a: assert property (
    i_acc_req && !i_acc_write && i_acc_lvl == VCIF_LVL_HYP && i_hyp_present && i_hyp_sre
    && i_acc_sel == VCIF_SEL_TYPE |=> s_clean ##0 o_acc_rdata == 32'h90100003)
    else $error("type word wrong");
  eoi_drop_a: assert property (
    i_eoi_req |=> o_prio_drop) else $error("no priority drop");
  dir_split_a: assert property (
    i_dir_req && !i_eoi_req |=> o_deact != o_dir_unpred) else $error("dir outcome wrong");
  ack_spur_a: assert property (
    i_ack_req && !i_pend_valid |=> o_ack_valid ##0 o_ack_id == 24'h0003ff)
    else $error("empty ack id wrong");
  no_pend_a: assert property (
    !i_pend_valid |=> !o_virq && !o_vfiq) else $error("signal without pending");
endmodule
bind vcif_ctrl_regs vcif_ctrl_assertions vcif_ctrl_assertions_i (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_hyp_present(i_hyp_present),
  .i_hyp_sre(i_hyp_sre), .i_cp15_trap(i_cp15_trap), .i_acc_req(i_acc_req),
  .i_acc_write(i_acc_write), .i_acc_ns(i_acc_ns), .i_acc_lvl(i_acc_lvl),
  .i_acc_sel(i_acc_sel), .o_acc_done(o_acc_done), .o_acc_undef(o_acc_undef),
  .o_acc_trap(o_acc_trap), .o_acc_rdata(o_acc_rdata), .i_pend_valid(i_pend_valid),
  .o_virq(o_virq), .o_vfiq(o_vfiq), .i_ack_req(i_ack_req), .i_eoi_req(i_eoi_req),
  .i_dir_req(i_dir_req), .o_ack_valid(o_ack_valid), .o_ack_id(o_ack_id),
  .o_prio_drop(o_prio_drop), .o_deact(o_deact), .o_dir_unpred(o_dir_unpred)
);

// File: tb/testbench.sv
// self-checking bench for the virtual interface control and type registers
// drives every port itself at the falling edge; no far-side model
`timescale 1ns/100ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module testbench;
  import vcif_pkg::*;
  logic i_sys_clk = '0, i_nrst = '0, i_hyp_present = 1'b1, i_hyp_sre = 1'b1;
  logic i_mon_sre = 1'b1, i_cp15_trap = '0, i_acc_req = '0, i_acc_write = '0;
  logic i_acc_ns = 1'b1, i_gst_req = '0, i_gst_write = '0;
  vcif_lvl_t i_acc_lvl = VCIF_LVL_HYP;
  vcif_sel_t i_acc_sel = VCIF_SEL_CTL;
  vcif_gsel_t i_gst_sel = VCIF_G_PMR;
  logic [31:0] i_acc_wdata = '0, o_acc_rdata;
  logic [7:0] i_gst_wdata = '0, o_gst_rdata, i_pend_prio = '0, i_run_prio = '0;
  logic [23:0] i_pend_id = 24'h000123, o_ack_id;
  logic i_pend_valid = '0, i_pend_grp1 = '0, i_run_active = '0;
  logic i_ack_req = '0, i_eoi_req = '0, i_dir_req = '0;
  logic o_acc_done, o_acc_undef, o_acc_trap, o_gst_done, o_virq, o_vfiq;
  logic o_ack_valid, o_prio_drop, o_deact, o_dir_unpred;
  int num_errors = 0, checked = 0;

  vcif_ctrl_regs vcif_ctrl_regs_i (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_hyp_present(i_hyp_present),
    .i_hyp_sre(i_hyp_sre), .i_mon_sre(i_mon_sre), .i_cp15_trap(i_cp15_trap),
    .i_acc_req(i_acc_req), .i_acc_write(i_acc_write), .i_acc_ns(i_acc_ns),
    .i_acc_lvl(i_acc_lvl), .i_acc_sel(i_acc_sel), .i_acc_wdata(i_acc_wdata),
    .o_acc_done(o_acc_done), .o_acc_undef(o_acc_undef), .o_acc_trap(o_acc_trap),
    .o_acc_rdata(o_acc_rdata), .i_gst_req(i_gst_req), .i_gst_write(i_gst_write),
    .i_gst_sel(i_gst_sel), .i_gst_wdata(i_gst_wdata), .o_gst_done(o_gst_done),
    .o_gst_rdata(o_gst_rdata), .i_pend_valid(i_pend_valid), .i_pend_grp1(i_pend_grp1),
    .i_pend_prio(i_pend_prio), .i_pend_id(i_pend_id), .i_run_active(i_run_active),
    .i_run_prio(i_run_prio), .o_virq(o_virq), .o_vfiq(o_vfiq), .i_ack_req(i_ack_req),
    .i_eoi_req(i_eoi_req), .i_dir_req(i_dir_req), .o_ack_valid(o_ack_valid),
    .o_ack_id(o_ack_id), .o_prio_drop(o_prio_drop), .o_deact(o_deact),
    .o_dir_unpred(o_dir_unpred)
  );

  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic tally_and_finish;
    $display("mismatches %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one hypervisor-port access; ut is the expected {undef, trap}
  task automatic hx(input logic wr, input vcif_lvl_t lvl, input vcif_sel_t sel,
                    input logic [31:0] wd, input logic [1:0] ut, input logic [31:0] exp);
    @(negedge i_sys_clk);
    i_acc_req = 1'b1;
    i_acc_write = wr;
    i_acc_lvl = lvl;
    i_acc_sel = sel;
    i_acc_wdata = wd;
    @(negedge i_sys_clk);
    i_acc_req = 1'b0;
    `CHK({o_acc_done, o_acc_undef, o_acc_trap}, {1'b1, ut})
    // refused reads carry no defined data
    if (ut == 2'h0) `CHK(o_acc_rdata, exp)
  endtask

  task automatic hw(input logic [31:0] wd);
    hx(1'b1, VCIF_LVL_HYP, VCIF_SEL_CTL, wd, 2'h0, 32'h00000000);
  endtask

  task automatic hr(input logic [31:0] exp);
    hx(1'b0, VCIF_LVL_HYP, VCIF_SEL_CTL, 32'h00000000, 2'h0, exp);
  endtask

  task automatic gx(input logic wr, input vcif_gsel_t sel, input logic [7:0] wd,
                    input logic [7:0] exp);
    @(negedge i_sys_clk);
    i_gst_req = 1'b1;
    i_gst_write = wr;
    i_gst_sel = sel;
    i_gst_wdata = wd;
    @(negedge i_sys_clk);
    i_gst_req = 1'b0;
    `CHK(o_gst_done, 1'b1)
    if (!wr) `CHK(o_gst_rdata, exp)
  endtask

  // req is {ack, eoi, dir}; exp is {drop, deact, unpred}
  task automatic pl(input logic [2:0] req, input logic [2:0] exp, input logic [23:0] id);
    @(negedge i_sys_clk);
    {i_ack_req, i_eoi_req, i_dir_req} = req;
    @(negedge i_sys_clk);
    {i_ack_req, i_eoi_req, i_dir_req} = 3'h0;
    if (req[2]) `CHK({o_ack_valid, o_ack_id}, {1'b1, id})
    else `CHK({o_prio_drop, o_deact, o_dir_unpred}, exp)
  endtask

  // exp is {virq, vfiq}
  task automatic sg(input logic [31:0] ctl, input logic g1, input logic [7:0] pr,
                    input logic [1:0] exp);
    hw(ctl);
    i_pend_grp1 = g1;
    i_pend_prio = pr;
    i_pend_valid = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    `CHK({o_virq, o_vfiq}, exp)
  endtask

  initial begin
    repeat (2000) @(posedge i_sys_clk);
    num_errors++;
    tally_and_finish;
  end

  initial begin
    repeat (6) @(negedge i_sys_clk);
    i_nrst = 1'b1;
    hr(32'h00040000);
    hx(1'b0, VCIF_LVL_HYP, VCIF_SEL_TYPE, '0, 2'h0, 32'h90100003);
    hw(32'hffffffef);
    hr(32'hfffc020f);
    gx(1'b0, VCIF_G_PMR, 8'h00, 8'hff);
    gx(1'b0, VCIF_G_CTL, 8'h00, 8'h0e);
    gx(1'b0, VCIF_G_EN1, 8'h00, 8'h01);
    gx(1'b1, VCIF_G_PMR, 8'h80, 8'h00);
    hr(32'h80fc020f);
    hw(32'h00e00010);
    gx(1'b0, VCIF_G_BPR1, 8'h00, 8'h07);
    hw(32'h00440010);
    gx(1'b0, VCIF_G_BPR1, 8'h00, 8'h03);
    gx(1'b1, VCIF_G_BPR1, 8'h05, 8'h00);
    hr(32'h00440010);
    i_cp15_trap = 1'b1;
    hx(1'b1, VCIF_LVL_KERNEL, VCIF_SEL_CTL, '1, 2'h1, '0);
    i_cp15_trap = 1'b0;
    hx(1'b0, VCIF_LVL_KERNEL, VCIF_SEL_CTL, '0, 2'h2, '0);
    hx(1'b0, VCIF_LVL_USER, VCIF_SEL_CTL, '0, 2'h2, '0);
    hx(1'b1, VCIF_LVL_HYP, VCIF_SEL_TYPE, '1, 2'h2, '0);
    i_hyp_sre = 1'b0;
    hx(1'b0, VCIF_LVL_HYP, VCIF_SEL_CTL, '0, 2'h2, '0);
    i_hyp_sre = 1'b1;
    i_mon_sre = 1'b0;
    hx(1'b0, VCIF_LVL_MON, VCIF_SEL_CTL, '0, 2'h2, '0);
    i_mon_sre = 1'b1;
    hr(32'h00440010);
    i_hyp_present = 1'b0;
    i_acc_ns = 1'b0;
    hx(1'b1, VCIF_LVL_MON, VCIF_SEL_CTL, '1, 2'h0, '0);
    hx(1'b0, VCIF_LVL_MON, VCIF_SEL_CTL, '0, 2'h0, 32'h00000000);
    hx(1'b0, VCIF_LVL_MON, VCIF_SEL_TYPE, '0, 2'h0, 32'h00100000);
    i_hyp_present = 1'b1;
    i_acc_ns = 1'b1;
    hr(32'h00440010);
    i_pend_grp1 = 1'b1;
    i_pend_valid = 1'b1;
    hw(32'h00000003);
    pl(3'h4, 3'h0, 24'h0003fe);
    pl(3'h2, 3'h6, 24'h0);
    pl(3'h1, 3'h1, 24'h0);
    hw(32'h00000207);
    pl(3'h4, 3'h0, 24'h000123);
    pl(3'h2, 3'h4, 24'h0);
    pl(3'h1, 3'h2, 24'h0);
    i_pend_valid = 1'b0;
    pl(3'h4, 3'h0, 24'h0003ff);
    sg(32'h80000003, 1'b0, 8'h40, 2'h2);
    sg(32'h8000000b, 1'b0, 8'h40, 2'h1);
    sg(32'h80000003, 1'b0, 8'h90, 2'h0);
    sg(32'h80000002, 1'b0, 8'h40, 2'h0);
    sg(32'h80000001, 1'b1, 8'h40, 2'h0);
    sg(32'h80000003, 1'b1, 8'h40, 2'h2);
    i_run_active = 1'b1;
    i_run_prio = 8'h40;
    sg(32'h80000003, 1'b0, 8'h20, 2'h2);
    sg(32'h80e00003, 1'b0, 8'h20, 2'h0);
    sg(32'h801c0003, 1'b1, 8'h20, 2'h0);
    sg(32'h801c0013, 1'b1, 8'h20, 2'h2);
    tally_and_finish;
  end
endmodule
